// [core/nte_consts.vh]
// Constants for the nibble transfer execution datapath.
// Assumes an including module that decodes 8-bit instruction bytes.
`ifndef NTE_CONSTS_VH
`define NTE_CONSTS_VH
// Operand-free opcodes use all eight bits.
`define NTE_OP_COPY_YREG_TO_ACC 8'h01
`define NTE_OP_COPY_ACC_TO_YREG 8'h02
`define NTE_OP_CLEAR_ACC 8'h03
`define NTE_OP_STORE_ACC_TO_RAM 8'h04
`define NTE_OP_STORE_ACC_RAM_INC_YREG 8'h05
`define NTE_OP_LOAD_YREG_FROM_RAM 8'h06
`define NTE_OP_LOAD_ACC_FROM_RAM 8'h07
`define NTE_OP_SWAP_RAM_ACC 8'h08
// Immediate forms: high nibble is the opcode, low nibble the operand.
`define NTE_OPHI_LOAD_YREG_IMMEDIATE 4'h4
`define NTE_OPHI_STORE_IMM_RAM_INC_YREG 4'h5
// Page load: upper six bits opcode, low two bits the page number.
`define NTE_OP6_LOAD_PAGE_REG_IMMEDIATE 6'h0C
// Reset values.
`define NTE_ACC_RST 4'h0
`define NTE_YREG_RST 4'h0
`define NTE_XREG_RST 2'h0
`define NTE_STATUS_RST 1'h0
`define NTE_RAM_RST 4'h0
`endif

// [core/nte_exec.v]
// Nibble transfer execution datapath: accumulator, Y index, X page register,
// a nibble RAM addressed by (X,Y) and the status flag.
// Assumes the fetch stage presents one decoded byte per cycle with instr_valid.
//
// Contract
// - copy Y into accumulator, Y unchanged.
// - copy accumulator into Y.
// - clear accumulator to zero.
// - store accumulator at RAM (X,Y).
// - store accumulator at (X,Y), then increment Y.
// - load Y from RAM (X,Y).
// - load accumulator from RAM (X,Y).
// - swap accumulator with RAM (X,Y).
// - load Y from 4-bit immediate.
// - store immediate at (X,Y), then increment Y.
// - load page register X from 2-bit immediate.
// - every instruction here sets status flag.
// - instructions are 8 bits, operand in low bits.
`timescale 1ns/1ps
`include "nte_consts.vh"

module nte_exec #(
  parameter PAGES = 4,
  parameter WORDS = 16
) (
  clk,
  rst,
  instr_valid,
  instr,
  acc,
  yreg,
  xreg,
  status_flag,
  instr_hit
);
  input wire clk;
  input wire rst;
  input wire instr_valid;
  input wire [7:0] instr;
  output wire [3:0] acc;
  output wire [3:0] yreg;
  output wire [1:0] xreg;
  output wire status_flag;
  output reg instr_hit;

  // Architectural registers and the values they take at the next edge.
  reg [3:0] acc_q;
  reg [3:0] acc_d;
  reg [3:0] yreg_q;
  reg [3:0] yreg_d;
  reg [1:0] xreg_q;
  reg [1:0] xreg_d;
  reg status_q;
  reg status_d;

  // Nibble RAM kept in flip-flops, with one write port and one read port.
  reg ram_we;
  reg [3:0] ram_wdata;
  reg [3:0] ram_q [0:PAGES*WORDS-1];
  wire [5:0] ram_idx;
  wire [3:0] ram_rdata;

  // Operand fields and the shared wrapping step of Y.
  wire [3:0] opnd4;
  wire [1:0] opnd2;
  wire [3:0] yreg_inc;

  // Decode strobes, one per instruction, each already qualified by instr_valid.
  wire dec_copy_y_acc;
  wire dec_copy_acc_y;
  wire dec_clear_acc;
  wire dec_store_acc;
  wire dec_store_acc_inc;
  wire dec_load_y_ram;
  wire dec_load_acc_ram;
  wire dec_swap;
  wire dec_load_y_imm;
  wire dec_store_imm_inc;
  wire dec_load_page;
  wire dec_known;
  integer i;

  // Operand-free forms match the whole byte, immediate forms only their opcode bits.
  // The encodings do not overlap, so at most one strobe is high in any cycle.
  assign dec_copy_y_acc = instr_valid && (instr == `NTE_OP_COPY_YREG_TO_ACC);
  assign dec_copy_acc_y = instr_valid && (instr == `NTE_OP_COPY_ACC_TO_YREG);
  assign dec_clear_acc = instr_valid && (instr == `NTE_OP_CLEAR_ACC);
  assign dec_store_acc = instr_valid && (instr == `NTE_OP_STORE_ACC_TO_RAM);
  assign dec_store_acc_inc = instr_valid && (instr == `NTE_OP_STORE_ACC_RAM_INC_YREG);
  assign dec_load_y_ram = instr_valid && (instr == `NTE_OP_LOAD_YREG_FROM_RAM);
  assign dec_load_acc_ram = instr_valid && (instr == `NTE_OP_LOAD_ACC_FROM_RAM);
  assign dec_swap = instr_valid && (instr == `NTE_OP_SWAP_RAM_ACC);
  assign dec_load_y_imm = instr_valid && (instr[7:4] == `NTE_OPHI_LOAD_YREG_IMMEDIATE);
  assign dec_store_imm_inc = instr_valid && (instr[7:4] == `NTE_OPHI_STORE_IMM_RAM_INC_YREG);
  assign dec_load_page = instr_valid && (instr[7:2] == `NTE_OP6_LOAD_PAGE_REG_IMMEDIATE);

  // Any recognised byte counts as executed; unknown bytes change nothing at all.
  assign dec_known = dec_copy_y_acc | dec_copy_acc_y | dec_clear_acc | dec_store_acc |
    dec_store_acc_inc | dec_load_y_ram | dec_load_acc_ram | dec_swap |
    dec_load_y_imm | dec_store_imm_inc | dec_load_page;

  // RAM index is page then word, so X selects a block of sixteen nibbles.
  assign ram_idx = {xreg_q, yreg_q};
  assign ram_rdata = ram_q[ram_idx];

  // Operands sit in the low bits of the instruction byte.
  assign opnd4 = instr[3:0];
  assign opnd2 = instr[1:0];

  // A 4-bit sum drops its carry, so Y steps from 15 back to 0 and nothing else notices.
  assign yreg_inc = yreg_q + 4'h1;

  // Data outputs come straight from the registers.
  assign acc = acc_q;
  assign yreg = yreg_q;
  assign xreg = xreg_q;
  assign status_flag = status_q;

  // Executed-instruction strobe; combinational, so it is valid in the cycle of the byte.
  always @* begin
    instr_hit = dec_known;
  end

  // Accumulator next value. The store forms fall through to the hold value, which
  // is what keeps the accumulator intact while RAM is written.
  always @* begin
    acc_d = acc_q;
    if (dec_copy_y_acc) begin
      acc_d = yreg_q;
    end else if (dec_clear_acc) begin
      acc_d = 4'h0;
    end else if (dec_load_acc_ram) begin
      acc_d = ram_rdata;
    end else if (dec_swap) begin
      // Old RAM nibble moves in while the old accumulator moves out, both on one edge.
      acc_d = ram_rdata;
    end
  end

  // Y next value. Both store-and-step forms address RAM with the Y of this cycle,
  // so the step only shows once the write has landed at the old word.
  always @* begin
    yreg_d = yreg_q;
    if (dec_copy_acc_y) begin
      yreg_d = acc_q;
    end else if (dec_store_acc_inc) begin
      yreg_d = yreg_inc;
    end else if (dec_load_y_ram) begin
      yreg_d = ram_rdata;
    end else if (dec_load_y_imm) begin
      yreg_d = opnd4;
    end else if (dec_store_imm_inc) begin
      yreg_d = yreg_inc;
    end
  end

  // Page register next value; only the page load writes it.
  always @* begin
    xreg_d = xreg_q;
    if (dec_load_page) begin
      xreg_d = opnd2;
    end
  end

  // Status goes to 1 on every executed instruction of this group. Nothing here
  // clears it, since the instruction groups that clear it live elsewhere in the core.
  always @* begin
    status_d = status_q;
    if (dec_known) begin
      status_d = 1'b1;
    end
  end

  // RAM write port. Loads never raise the enable, so reading leaves the nibble alone.
  always @* begin
    ram_we = 1'b0;
    ram_wdata = acc_q;
    if (dec_store_acc) begin
      ram_we = 1'b1;
    end else if (dec_store_acc_inc) begin
      ram_we = 1'b1;
    end else if (dec_swap) begin
      ram_we = 1'b1;
    end else if (dec_store_imm_inc) begin
      ram_we = 1'b1;
      ram_wdata = opnd4;
    end
  end

  // Accumulator register.
  always @(posedge clk) begin
    if (rst) begin
      acc_q <= `NTE_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Y index register.
  always @(posedge clk) begin
    if (rst) begin
      yreg_q <= `NTE_YREG_RST;
    end else begin
      yreg_q <= yreg_d;
    end
  end

  // Page register.
  always @(posedge clk) begin
    if (rst) begin
      xreg_q <= `NTE_XREG_RST;
    end else begin
      xreg_q <= xreg_d;
    end
  end

  // Status register.
  always @(posedge clk) begin
    if (rst) begin
      status_q <= `NTE_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // RAM array. Clearing every nibble on reset costs a wide reset fan-out but gives
  // a known memory image; the write uses the (X,Y) of the same cycle.
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < PAGES*WORDS; i = i + 1) begin
        ram_q[i] <= `NTE_RAM_RST;
      end
    end else if (ram_we) begin
      ram_q[ram_idx] <= ram_wdata;
    end
  end
endmodule

// [sim/nte_exec_monitor.sv]
// Port checker for nte_exec.
// Assumes one clock with a synchronous reset.
`timescale 1ns/1ps
module nte_exec_monitor (
  input wire clk,
  input wire rst,
  input wire instr_valid,
  input wire [7:0] instr,
  input wire [3:0] acc,
  input wire [3:0] yreg,
  input wire [1:0] xreg,
  input wire status_flag,
  input wire instr_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire v = instr_valid;
  // Both store-and-step forms advance Y; a 4-bit sum wraps by itself.
  sequence s_inc;
    v && (instr == 8'h05 || instr[7:4] == 4'h5);
  endsequence
  AST_Y2A: assert property (v && instr == 8'h01 |=> acc == $past(yreg) && $stable(yreg)) else $error("y2a");
  AST_A2Y: assert property (v && instr == 8'h02 |=> yreg == $past(acc)) else $error("a2y");
  AST_CLR: assert property (v && instr == 8'h03 |=> acc == 4'h0) else $error("clr");
  AST_KEEP: assert property (v && instr == 8'h04 |=> $stable(acc) && $stable(yreg)) else $error("keep");
  AST_INC: assert property (s_inc |=> yreg == $past(yreg) + 4'h1) else $error("inc");
  AST_LDY: assert property (v && instr[7:4] == 4'h4 |=> yreg == $past(instr[3:0])) else $error("ldy");
  AST_PAGE: assert property (v && instr[7:2] == 6'h0C |=> xreg == $past(instr[1:0])) else $error("page");
  AST_STAT: assert property (v && instr == 8'h06 |-> instr_hit ##1 status_flag) else $error("stat");
endmodule
bind nte_exec nte_exec_monitor u_mon (.clk, .rst, .instr_valid, .instr, .acc, .yreg, .xreg, .status_flag, .instr_hit);

// [sim/nte_exec_tb.sv]
// Bench for nte_exec: corner bytes first, then seeded random bytes.
// Assumes the monitor binds itself to the design.
`timescale 1ns/1ps
module nte_exec_tb;
  reg clk = 0, rst = 1, instr_valid = 0, es = 0, h;
  reg [7:0] instr = 8'h00, t;
  reg [3:0] ea = 0, ey = 0, m [0:63];
  reg [1:0] ex = 0;
  integer miscompares = 0, tests_run = 0, i, a, p;
  wire [3:0] acc, yreg;
  wire [1:0] xreg;
  wire status_flag, instr_hit;
  nte_exec u_dut (.clk, .rst, .instr_valid, .instr, .acc, .yreg, .xreg, .status_flag, .instr_hit);
  // Half period of 50 ns gives 10 MHz.
  initial forever #50 clk = ~clk;
  // Compares status, X, Y and accumulator with the reference.
  task check(input [10:0] e, g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] regs exp %h got %h", e, g);
    end
  endtask
  // Compares the executed-instruction strobe with the reference.
  task check_hit(input e, g);
    tests_run++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] instr_hit exp %h got %h", e, g);
    end
  endtask
  // True for the bytes this group executes, from the opcode table.
  function known(input [7:0] b);
    known = (b >= 8'h01 && b <= 8'h08) || b[7:5] == 3'b010 || b[7:2] == 6'h0C;
  endfunction
  // Prints the counts and the verdict, then stops.
  task summarize;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Two reset passes, the second in mid-run. Each opens with eight bytes that force Y wraps
  // and a double swap of unequal nibbles, since random traffic hits them rarely.
  initial begin
    i = $urandom(27895);
    for (p = 0; p < 2; p++) begin
      rst = 1;
      instr_valid = 0;
      repeat (3) @(negedge clk);
      rst = 0;
      {es, ex, ey, ea} = 0;
      for (i = 0; i < 64; i++) m[i] = 0;
      @(negedge clk);
      check(11'h000, {status_flag, xreg, yreg, acc});
      for (i = 0; i < 400; i++) begin
        t = 8'($urandom);
        case ($urandom % 4)
          0: t = t[2:0] + 8'h01;
          1: t[7:5] = 3'b010;
          2: t[7:2] = 6'h0C;
        endcase
        if (i < 8) t = 8'(64'h0508_0801_4F5A_314F >> 8 * i);
        h = i < 8 || $urandom % 8 > 0;
        instr = t;
        instr_valid = h;
        h = h && known(t);
        #10 check_hit(h, instr_hit);
        a = {ex, ey};
        if (h) casez (t)
          8'h01: ea = ey;
          8'h02: ey = ea;
          8'h03: ea = 0;
          8'h04, 8'h05: m[a] = ea;
          8'h06: ey = m[a];
          8'h07: ea = m[a];
          8'h08: {ea, m[a]} = {m[a], ea};
          8'h4?: ey = t[3:0];
          8'h5?: m[a] = t[3:0];
          8'b0011_00??: ex = t[1:0];
          default: h = 0;
        endcase
        if (h && (t == 8'h05 || t[7:4] == 4'h5)) ey++;
        es |= h;
        @(negedge clk);
        check({es, ex, ey, ea}, {status_flag, xreg, yreg, acc});
      end
    end
    summarize;
  end
endmodule
